// *** src/ucrb_bridge.sv ***
// AHB-lite slave bridging indirect reads and posted writes to the USB device core
`timescale 1ns/1ps
module ucrb_bridge
  import ucrb_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst,
  // AHB-lite slave
  input  wire logic                      hsel,
  input  wire logic [9:0]                haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic                      hready,
  input  wire logic [UCRB_DATA_W-1:0]    hwdata,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic      [UCRB_DATA_W-1:0]    hrdata,
  // USB device core register port
  output logic                           core_req,
  output logic                           core_we,
  output logic      [UCRB_ADR_W-1:0]     core_addr,
  output logic      [UCRB_CORE_W-1:0]    core_wdata,
  input  wire logic                      core_ack,
  input  wire logic [UCRB_CORE_W-1:0]    core_rdata,
  // DMA controller read return
  input  wire logic                      dma_rd_done,
  input  wire logic [UCRB_DATA_W-1:0]    dma_rd_data,
  // Done flag level
  output logic                           core_reg_read_done_flag
);

  typedef struct packed {
    logic                      dph_valid;
    logic                      dph_write;
    logic [9:0]                dph_addr;
    logic                      err1;
    logic                      err2;
    logic [UCRB_DATA_W-1:0]    rdata;
    logic                      req;
    logic                      clr;
    logic                      op_wr;
    logic [UCRB_ADR_W-1:0]     adr;
    logic [UCRB_ADR_W-1:0]     cadr;
    logic [UCRB_CORE_W-1:0]    wdata;
    logic                      done;
  } ucrb_state_s;

  ucrb_state_s s_q;
  ucrb_state_s s_d;

  logic [UCRB_DATA_W-1:0] dma_read_value;
  logic [UCRB_CORE_W-1:0] core_read_value;
  logic                   core_load;
  logic                   abort_now;
  logic                   dph_wr;
  logic                   accept;

  //////////////////////////////////////////////////////////////////////////////
  // Read-value registers

  ucrb_capture #(.W(UCRB_DATA_W)) u_dma_value (
    .clk  (clk),
    .rst  (rst),
    .load (dma_rd_done),
    .din  (dma_rd_data),
    .q    (dma_read_value)
  );

  ucrb_capture #(.W(UCRB_CORE_W)) u_core_value (
    .clk  (clk),
    .rst  (rst),
    .load (core_load),
    .din  (core_rdata),
    .q    (core_read_value)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode helpers

  assign dph_wr    = s_q.dph_valid & s_q.dph_write;
  assign accept    = hsel & htrans[UCRB_HTRANS_ACT_BIT] & hready;
  assign abort_now = dph_wr & (s_q.dph_addr == UCRB_OFS_CORE_RDREQ) & hwdata[UCRB_CLR_BIT];
  assign core_load = s_q.req & ~s_q.op_wr & core_ack & ~abort_now;

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d = s_q;
    s_d.clr  = 1'b0;
    s_d.err2 = s_q.err1;
    s_d.err1 = 1'b0;

    // Core completion
    if (s_q.req && core_ack) begin
      s_d.req = 1'b0;
    end

    // Data-phase write effects
    if (dph_wr && !s_q.dph_addr[UCRB_CORE_WIN_BIT]) begin
      unique case (s_q.dph_addr)
        UCRB_OFS_CORE_RDREQ: begin
          if (hwdata[UCRB_CLR_BIT]) begin
            s_d.clr = 1'b1;
            s_d.req = 1'b0;
          end else if (!s_q.req) begin
            s_d.adr = hwdata[UCRB_ADR_MSB:UCRB_ADR_LSB];
            if (hwdata[UCRB_REQ_BIT]) begin
              s_d.req   = 1'b1;
              s_d.op_wr = 1'b0;
              s_d.cadr  = hwdata[UCRB_ADR_MSB:UCRB_ADR_LSB];
            end
          end
        end
        UCRB_OFS_INT_STS: begin
          if (hwdata[UCRB_DONE_BIT]) begin
            s_d.done = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end else if (dph_wr) begin
      s_d.req   = 1'b1;
      s_d.op_wr = 1'b1;
      s_d.cadr  = s_q.dph_addr[UCRB_ADR_MSB:UCRB_ADR_LSB];
      s_d.wdata = hwdata[UCRB_CORE_W-1:0];
    end

    if (core_load) begin
      s_d.done = 1'b1;
    end

    // Address phase
    s_d.dph_valid = 1'b0;
    s_d.dph_write = 1'b0;
    s_d.dph_addr  = haddr;
    s_d.rdata     = UCRB_WORD_RST;
    if (accept) begin
      if (haddr[UCRB_CORE_WIN_BIT] && (s_d.req || s_d.clr)) begin
        s_d.err1 = 1'b1;
      end else begin
        s_d.dph_valid = 1'b1;
        s_d.dph_write = hwrite;
        if (!hwrite) begin
          unique case (haddr)
            UCRB_OFS_DMA_RDVL:   s_d.rdata = dma_read_value;
            UCRB_OFS_CORE_RDREQ: begin
              s_d.rdata[UCRB_REQ_BIT]                = s_d.req;
              s_d.rdata[UCRB_CLR_BIT]                = s_d.clr;
              s_d.rdata[UCRB_ADR_MSB:UCRB_ADR_LSB]   = s_d.adr;
            end
            UCRB_OFS_CORE_RDVL:  s_d.rdata[UCRB_CORE_W-1:0] = core_read_value;
            UCRB_OFS_INT_STS:    s_d.rdata[UCRB_DONE_BIT]   = s_d.done;
            default: begin
            end
          endcase
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign hreadyout               = ~s_q.err1;
  assign hresp                   = s_q.err1 | s_q.err2;
  assign hrdata                  = s_q.rdata;
  assign core_req                = s_q.req;
  assign core_we                 = s_q.op_wr;
  assign core_addr               = s_q.cadr;
  assign core_wdata              = s_q.wdata;
  assign core_reg_read_done_flag = s_q.done;

endmodule : ucrb_bridge

// *** src/ucrb_pkg.sv ***
// Constants and register layout of the core register access bridge
package ucrb_pkg;

  // Byte offsets of the bridge registers
  localparam logic [9:0] UCRB_OFS_DMA_RDVL   = 10'h000;
  localparam logic [9:0] UCRB_OFS_CORE_RDREQ = 10'h004;
  localparam logic [9:0] UCRB_OFS_CORE_RDVL  = 10'h008;
  localparam logic [9:0] UCRB_OFS_INT_STS    = 10'h00C;
  // Address bit that selects the core register window (0x200 to 0x3FF)
  localparam int         UCRB_CORE_WIN_BIT   = 9;

  // Field positions of the core read-request register
  localparam int         UCRB_REQ_BIT        = 31;
  localparam int         UCRB_CLR_BIT        = 30;
  localparam int         UCRB_ADR_MSB        = 9;
  localparam int         UCRB_ADR_LSB        = 2;
  // Done flag position in the interrupt status register
  localparam int         UCRB_DONE_BIT       = 0;

  // Widths
  localparam int         UCRB_DATA_W         = 32;
  localparam int         UCRB_CORE_W         = 16;
  localparam int         UCRB_ADR_W          = 8;
  localparam int         UCRB_DMA_ADR_W      = 6;

  // Reset values
  localparam logic [7:0]  UCRB_ADR_RST       = 8'h00;
  localparam logic [15:0] UCRB_CORE_RST      = 16'h0000;
  localparam logic [31:0] UCRB_WORD_RST      = 32'h0000_0000;

  // AHB transfer type bit that marks NONSEQ or SEQ
  localparam int         UCRB_HTRANS_ACT_BIT = 1;

endpackage : ucrb_pkg

// *** src/ucrb_capture.sv ***
// Read-value holding register, loaded on a one-cycle strobe
`timescale 1ns/1ps
module ucrb_capture #(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] val;
  } ucrb_cap_s;

  ucrb_cap_s s_q;
  ucrb_cap_s s_d;

  always_comb begin
    s_d = s_q;
    if (load) begin
      s_d.val = din;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.val;

endmodule : ucrb_capture

// *** test/ucrb_props.sv ***
// Port assertions for the core register access bridge
`timescale 1ns/1ps
module ucrb_props (
  input wire logic        clk, rst, hsel, hwrite, hready, hreadyout, hresp,
  input wire logic        core_req, core_we, core_ack, core_reg_read_done_flag,
  input wire logic [1:0]  htrans,
  input wire logic [9:0]  haddr,
  input wire logic [31:0] hwdata,
  input wire logic [7:0]  core_addr,
  input wire logic [15:0] core_wdata
);
  logic [1:0] h_q;
  wire logic tk = hsel & htrans[1] & hready;
  wire logic abt = h_q[0] & hwdata[30];
  wire logic [7:0] wadr = hwdata[9:2];
  wire logic [15:0] wlo = hwdata[15:0];
  // Data phase of a request write, then clear pending
  always_ff @(posedge clk or posedge rst)
    if (rst) h_q <= 2'b00;
    else h_q <= {abt, tk & hwrite & (haddr == 10'h004)};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  rd_start_a: assert property (h_q[0] && hwdata[31:30] == 2'b10 && !core_req |=>
    core_req && !core_we && core_addr == $past(wadr)) else $error("read start");
  zero_req_a: assert property (h_q[0] && !hwdata[31] && !core_req |=> !core_req)
    else $error("zero write");
  abort_a: assert property (abt |=> !core_req) else $error("abort");
  busy_err_a: assert property (tk && haddr[9] && core_req && !core_ack |=>
    !hreadyout && hresp ##1 hreadyout && hresp) else $error("busy error");
  wr_busy_a: assert property (tk && hwrite && haddr[9] && !core_req && h_q == 2'b00 |=> ##1
    core_req && core_we && core_wdata == $past(wlo)) else $error("core write");
  hold_a: assert property (core_req && !core_ack && !abt |=> core_req && $stable(core_addr))
    else $error("hold");
  done_a: assert property (core_req && !core_we && core_ack && !abt |=>
    !core_req && core_reg_read_done_flag) else $error("done");
  fell_a: assert property ($fell(core_req) |-> $past(core_ack) || $past(abt))
    else $error("req drop");
endmodule : ucrb_props

// *** test/ucrb_core_model.sv ***
// Behavioural model of the USB device core register port
`timescale 1ns/1ps
module ucrb_core_model #(parameter int DLY = 16) (
  input wire logic        clk, rst, core_req,
  input wire logic [7:0]  core_addr,
  output logic            core_ack,
  output logic     [15:0] core_rdata
);
  logic [7:0] cnt_q;
  // Acknowledge after DLY waiting cycles
  always_ff @(posedge clk or posedge rst)
    if (rst) cnt_q <= 8'h00;
    else cnt_q <= (core_req && !core_ack) ? cnt_q + 8'h01 : 8'h00;
  assign core_ack = core_req && cnt_q == 8'(DLY);
  // Read data valid only with the acknowledge
  assign core_rdata = core_ack ? {core_addr, 8'hA5} : {~core_addr, 8'h5A};
endmodule : ucrb_core_model

// *** test/tb.sv ***
// Self-checking bench for the core register access bridge
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst = 1'b1, hwrite = 1'b0, dma_rd_done = 1'b0, e;
  logic [1:0] htrans = 2'b00;
  logic [9:0] haddr = 10'h000;
  logic [31:0] hwdata = 32'h0, dma_rd_data = 32'h5A5A_C3C3, hrdata, r;
  logic hreadyout, hresp, core_req, core_we, core_ack, core_reg_read_done_flag;
  logic [7:0] core_addr;
  logic [15:0] core_wdata, core_rdata;
  int bad_count = 0, num_checks = 0;
  ucrb_bridge u_ucrb_bridge (.clk, .rst, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hready(hreadyout), .hwdata, .hreadyout, .hresp, .hrdata, .core_req, .core_we, .core_addr,
    .core_wdata, .core_ack, .core_rdata, .dma_rd_done, .dma_rd_data, .core_reg_read_done_flag);
  ucrb_core_model u_ucrb_core_model (.clk, .rst, .core_req, .core_addr, .core_ack, .core_rdata);
  initial forever #50 clk = ~clk;
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic xfer(input logic [9:0] a, input logic w, input logic [31:0] d);
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    @(posedge clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    e = hresp;
    r = hrdata;
  endtask : xfer
  task automatic rd(input logic [9:0] a, input logic [31:0] x);
    xfer(a, 1'b0, 32'h0);
    chk("hrdata", x, r);
  endtask : rd
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic x);
    xfer(a, 1'b1, d);
    chk("hresp", {31'h0, x}, {31'h0, e});
  endtask : wr
  task automatic idle;
    for (int i = 0; i < 60 && core_req !== 1'b0; i++) @(posedge clk);
  endtask : idle
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (2000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(10'h004, 32'h0);
    rd(10'h010, 32'h0);
    wr(10'h004, 32'h8000_0214, 1'b0);
    rd(10'h004, 32'h8000_0214);
    xfer(10'h214, 1'b0, 32'h0);
    chk("hresp", 32'h1, {31'h0, e});
    idle();
    rd(10'h008, 32'h0000_85A5);
    chk("done_flag", 32'h1, {31'h0, core_reg_read_done_flag});
    rd(10'h00C, 32'h1);
    wr(10'h00C, 32'h1, 1'b0);
    rd(10'h00C, 32'h0);
    chk("done_flag", 32'h0, {31'h0, core_reg_read_done_flag});
    rd(10'h004, 32'h0000_0214);
    $display("read test done");
    wr(10'h2A0, 32'h0000_1234, 1'b0);
    xfer(10'h004, 1'b0, 32'h0);
    chk("busy", 32'h8000_0000, r & 32'hC000_0000);
    wr(10'h2A4, 32'h1, 1'b1);
    wr(10'h004, 32'h4000_0000, 1'b0);
    wr(10'h004, 32'hC000_0220, 1'b0);
    rd(10'h004, 32'h0000_0214);
    wr(10'h004, 32'h0000_0220, 1'b0);
    rd(10'h004, 32'h0000_0220);
    wr(10'h2A8, 32'h5, 1'b0);
    dma_rd_done <= 1'b1;
    @(posedge clk);
    dma_rd_done <= 1'b0;
    rd(10'h000, 32'h5A5A_C3C3);
    $display("write abort dma test done");
    tally_and_finish();
  end
endmodule : tb
bind ucrb_bridge ucrb_props u_ucrb_props (.clk, .rst, .hsel, .hwrite, .hready, .hreadyout,
  .hresp, .core_req, .core_we, .core_ack, .core_reg_read_done_flag, .htrans, .haddr, .hwdata,
  .core_addr, .core_wdata);
